// >>> eeprom_pkg.sv
/*
 * Shared constants, types and helpers for the serial memory command engine.
 * Assumes one engine per package user; the system clock runs at 40 MHz.
 */
package eeprom_pkg;

  // ************************************************************
  // geometry
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int PAGE_W = 4;
  localparam int OFS_W = 4;
  localparam int PAGE_BYTES = 16;
  localparam int MEM_BYTES = 256;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [OFS_W-1:0] OFS_ZERO = 4'h0;
  localparam logic [OFS_W-1:0] OFS_STEP = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 8'h01;

  // ************************************************************
  // instruction encoding: upper nibble zero, bit 3 ignored
  // ************************************************************
  localparam logic [3:0] OPC_HI = 4'h0;
  localparam logic [2:0] OPL_READ = 3'h3;
  localparam logic [2:0] OPL_WRITE = 3'h2;
  localparam logic [2:0] OPL_LATCH_CLR = 3'h4;
  localparam logic [2:0] OPL_LATCH_SET = 3'h6;
  localparam logic [2:0] OPL_STAT_RD = 3'h5;
  localparam logic [2:0] OPL_STAT_WR = 3'h1;

  // ************************************************************
  // status register layout and guard codes
  // ************************************************************
  localparam int STAT_BUSY = 0;
  localparam int STAT_PERMIT = 1;
  localparam int STAT_BP = 2;
  localparam logic [1:0] BP_RST = 2'h1;
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QTR = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [ADDR_W-1:0] PROT_QTR_BASE = 8'hC0;
  localparam logic [ADDR_W-1:0] PROT_HALF_BASE = 8'h80;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned TWC_NS = 5000000;
  localparam int unsigned SYS_CLK_NS = 25;
  localparam int unsigned TWC_CYCLES_DEF = TWC_NS / SYS_CLK_NS;
  localparam int CNT_W = 18;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [2:0] {ACT_NONE, ACT_SET, ACT_CLR, ACT_SWR, ACT_WR} act_t;

  typedef enum logic [2:0] {
    ST_OPC, ST_RADDR, ST_WADDR, ST_RDATA, ST_WDATA, ST_SRD, ST_SWR, ST_IDLE
  } link_st_t;

  // command left behind by a frame, read by the system side at frame end
  typedef struct packed {
    act_t act;
    logic [PAGE_W-1:0] page;
    logic [DATA_W-1:0] data;
  } xfer_t;

  function automatic logic page_locked(input logic [1:0] bp, input logic [PAGE_W-1:0] page);
    logic [ADDR_W-1:0] base;
    logic res;
    base = {page, OFS_ZERO};
    unique case (bp)
      BP_NONE: res = 1'b0;
      BP_QTR: res = (base >= PROT_QTR_BASE);
      BP_HALF: res = (base >= PROT_HALF_BASE);
      default: res = 1'b1;
    endcase
    return res;
  endfunction : page_locked

endpackage : eeprom_pkg

// >>> eeprom_spi_engine.sv
/*
 * Serial command engine of a 256-byte nonvolatile memory with a four-wire serial slave.
 * Assumes si and hold_n are timed to sck by the host; cs_n and wp_n are asynchronous.
 */
`timescale 1ns/100ps
module eeprom_spi_engine #(
  parameter int unsigned WRITE_CYCLES = eeprom_pkg::TWC_CYCLES_DEF
) (
  input wire logic sys_clk, // system clock, 40 MHz
  input wire logic rst_b, // asynchronous reset, active low
  input wire logic clk_en, // freezes system-side state while low
  input wire logic sck, // serial clock from the host
  input wire logic cs_n, // chip select, active low
  input wire logic si, // serial data in
  input wire logic hold_n, // pause, active low
  input wire logic wp_n, // write protect, active low
  output logic so_o, // serial data out
  output logic so_oe // output enable for so_o
);

  // ************************************************************
  // system reset and pin synchronisers
  // ************************************************************
  logic rst_meta_r, rst_sync_r;
  logic cs_meta_r, cs_s_r, cs_d_r;
  logic wp_meta_r, wp_s_r;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      cs_meta_r <= 1'b1;
      cs_s_r <= 1'b1;
      cs_d_r <= 1'b1;
      wp_meta_r <= 1'b0;
      wp_s_r <= 1'b0;
    end else if (clk_en) begin
      cs_meta_r <= cs_n;
      cs_s_r <= cs_meta_r;
      cs_d_r <= cs_s_r;
      wp_meta_r <= wp_n;
      wp_s_r <= wp_meta_r;
    end
  end

  // ************************************************************
  // shared storage and status
  // ************************************************************
  // the array only changes while busy is set, and reads are refused then,
  // so the link side may read it directly without a word crossing
  logic [eeprom_pkg::DATA_W-1:0] mem_r [eeprom_pkg::MEM_BYTES];
  logic [eeprom_pkg::DATA_W-1:0] pbuf_r [eeprom_pkg::PAGE_BYTES];
  logic [eeprom_pkg::PAGE_BYTES-1:0] wmask_r;
  eeprom_pkg::xfer_t xfer_r;
  logic ok_r, tok_r, seen_r;
  logic permit_r, busy_r;
  logic [1:0] bp_r;
  logic [eeprom_pkg::CNT_W-1:0] cnt_r;
  logic [eeprom_pkg::DATA_W-1:0] status_w;

  always_comb begin
    status_w = '0;
    status_w[eeprom_pkg::STAT_BUSY] = busy_r;
    status_w[eeprom_pkg::STAT_PERMIT] = permit_r;
    status_w[eeprom_pkg::STAT_BP +: 2] = bp_r;
  end

  // ************************************************************
  // frame end: command commit on the system clock
  // ************************************************************
  // sck has stopped once cs_n is seen high through two flops, so the
  // descriptor left by the link side is quiet and may be read here
  logic frame_end, commit, set_go, clr_go, swr_go, wr_go, busy_done;

  assign frame_end = clk_en && cs_s_r && !cs_d_r;
  assign commit = frame_end && ok_r && (tok_r != seen_r);
  assign set_go = commit && (xfer_r.act == eeprom_pkg::ACT_SET);
  assign clr_go = commit && (xfer_r.act == eeprom_pkg::ACT_CLR);
  assign swr_go = commit && (xfer_r.act == eeprom_pkg::ACT_SWR) && permit_r && wp_s_r && !busy_r;
  assign wr_go = commit && (xfer_r.act == eeprom_pkg::ACT_WR) && permit_r && wp_s_r && !busy_r
      && !eeprom_pkg::page_locked(bp_r, xfer_r.page);
  assign busy_done = clk_en && busy_r && (cnt_r == '0);

  always_ff @(posedge sys_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      seen_r <= 1'b0;
    end else if (frame_end) begin
      seen_r <= tok_r;
    end
  end

  // ************************************************************
  // write permit latch
  // ************************************************************
  // a low protect pin beats a latch-set in the same cycle
  always_ff @(posedge sys_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      permit_r <= 1'b0;
    end else if (clk_en) begin
      if (!wp_s_r) begin
        permit_r <= 1'b0;
      end else if (busy_done) begin
        permit_r <= 1'b0;
      end else if (set_go) begin
        permit_r <= 1'b1;
      end else if (clr_go) begin
        permit_r <= 1'b0;
      end
    end
  end

  // ************************************************************
  // block guard bits
  // ************************************************************
  always_ff @(posedge sys_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      bp_r <= eeprom_pkg::BP_RST;
    end else if (swr_go) begin
      bp_r <= xfer_r.data[eeprom_pkg::STAT_BP +: 2];
    end
  end

  // ************************************************************
  // programming timer
  // ************************************************************
  always_ff @(posedge sys_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      busy_r <= 1'b0;
      cnt_r <= '0;
    end else if (wr_go || swr_go) begin
      busy_r <= 1'b1;
      cnt_r <= eeprom_pkg::CNT_W'(WRITE_CYCLES - 1);
    end else if (busy_done) begin
      busy_r <= 1'b0;
    end else if (clk_en && busy_r) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  // page buffer goes into the array at the start of the cycle, one pass
  always_ff @(posedge sys_clk) begin
    if (wr_go) begin
      for (int i = 0; i < eeprom_pkg::PAGE_BYTES; i++) begin
        if (wmask_r[i]) begin
          mem_r[{xfer_r.page, eeprom_pkg::OFS_W'(i)}] <= pbuf_r[i];
        end
      end
    end
  end

  // ************************************************************
  // link side: status crossing into sck
  // ************************************************************
  // sck runs only inside frames; the first two edges of a frame may still
  // show the previous status, well before any decision reads it
  logic [eeprom_pkg::DATA_W-1:0] stat_meta_r, stat_k_r;

  always_ff @(posedge sck or negedge rst_b) begin
    if (!rst_b) begin
      stat_meta_r <= '0;
      stat_k_r <= '0;
    end else begin
      stat_meta_r <= status_w;
      stat_k_r <= stat_meta_r;
    end
  end

  // ************************************************************
  // link side: frame shifter and decoder
  // ************************************************************
  logic frame_rst_n;
  eeprom_pkg::link_st_t state_r;
  logic [2:0] bit_cnt_r;
  logic [eeprom_pkg::DATA_W-1:0] shift_r, tx_r, byte_w;
  logic [eeprom_pkg::ADDR_W-1:0] ptr_r;
  logic byte_done, is_op, link_busy;

  // a high select clears the shifter, decoder and output state, so every frame restarts at bit 7
  assign frame_rst_n = rst_b & ~cs_n;
  assign byte_w = {shift_r[eeprom_pkg::DATA_W-2:0], si};
  assign byte_done = hold_n && (bit_cnt_r == eeprom_pkg::BIT_LAST);
  assign is_op = (byte_w[7:4] == eeprom_pkg::OPC_HI);
  assign link_busy = stat_k_r[eeprom_pkg::STAT_BUSY];

  always_ff @(posedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt_r <= '0;
      shift_r <= '0;
    end else if (hold_n) begin
      bit_cnt_r <= bit_cnt_r + 1'b1;
      shift_r <= byte_w;
    end
  end

  always_ff @(posedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      state_r <= eeprom_pkg::ST_OPC;
      ptr_r <= '0;
      tx_r <= '0;
    end else if (hold_n) begin
      tx_r <= {tx_r[eeprom_pkg::DATA_W-2:0], 1'b0};
      if (byte_done) begin
        unique case (state_r)
          eeprom_pkg::ST_OPC: begin
            state_r <= eeprom_pkg::ST_IDLE;
            if (is_op && byte_w[2:0] == eeprom_pkg::OPL_READ && !link_busy) begin
              state_r <= eeprom_pkg::ST_RADDR;
            end
            if (is_op && byte_w[2:0] == eeprom_pkg::OPL_WRITE && !link_busy) begin
              state_r <= eeprom_pkg::ST_WADDR;
            end
            if (is_op && byte_w[2:0] == eeprom_pkg::OPL_STAT_RD) begin
              state_r <= eeprom_pkg::ST_SRD;
              tx_r <= stat_k_r;
            end
            if (is_op && byte_w[2:0] == eeprom_pkg::OPL_STAT_WR) begin
              state_r <= eeprom_pkg::ST_SWR;
            end
          end
          eeprom_pkg::ST_RADDR: begin
            state_r <= eeprom_pkg::ST_RDATA;
            tx_r <= mem_r[byte_w];
            ptr_r <= byte_w + eeprom_pkg::ADDR_STEP;
          end
          eeprom_pkg::ST_RDATA: begin
            tx_r <= mem_r[ptr_r];
            ptr_r <= ptr_r + eeprom_pkg::ADDR_STEP;
          end
          eeprom_pkg::ST_SRD: begin
            tx_r <= stat_k_r;
          end
          eeprom_pkg::ST_WADDR: begin
            state_r <= eeprom_pkg::ST_WDATA;
            ptr_r <= byte_w;
          end
          eeprom_pkg::ST_WDATA: begin
            ptr_r <= {ptr_r[eeprom_pkg::ADDR_W-1 -: eeprom_pkg::PAGE_W],
                      ptr_r[eeprom_pkg::OFS_W-1:0] + eeprom_pkg::OFS_STEP};
          end
          eeprom_pkg::ST_SWR, eeprom_pkg::ST_IDLE: begin
            state_r <= eeprom_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // link side: frame descriptor handed to the system clock
  // ************************************************************
  // kept through the select rise on purpose: only rst_b clears it.
  // tok_r flips on each frame's first edge so an edgeless frame never
  // commits the previous frame's command a second time
  logic frame_first, ok_nxt;

  assign frame_first = hold_n && (state_r == eeprom_pkg::ST_OPC) && (bit_cnt_r == '0);

  always_comb begin
    ok_nxt = 1'b0;
    if (byte_done && state_r == eeprom_pkg::ST_OPC && is_op) begin
      ok_nxt = (byte_w[2:0] == eeprom_pkg::OPL_LATCH_SET) || (byte_w[2:0] == eeprom_pkg::OPL_LATCH_CLR);
    end
    if (byte_done && (state_r == eeprom_pkg::ST_WDATA || state_r == eeprom_pkg::ST_SWR)) begin
      ok_nxt = 1'b1;
    end
  end

  always_ff @(posedge sck or negedge rst_b) begin
    if (!rst_b) begin
      ok_r <= 1'b0;
      tok_r <= 1'b0;
      xfer_r <= '0;
      wmask_r <= '0;
    end else if (hold_n) begin
      ok_r <= ok_nxt;
      if (frame_first) begin
        tok_r <= ~tok_r;
      end
      if (byte_done && state_r == eeprom_pkg::ST_OPC && is_op) begin
        xfer_r.act <= (byte_w[2:0] == eeprom_pkg::OPL_LATCH_SET) ? eeprom_pkg::ACT_SET
            : eeprom_pkg::ACT_CLR;
      end
      if (byte_done && state_r == eeprom_pkg::ST_SWR) begin
        xfer_r.act <= eeprom_pkg::ACT_SWR;
        xfer_r.data <= byte_w;
      end
      if (byte_done && state_r == eeprom_pkg::ST_WADDR) begin
        wmask_r <= '0;
        xfer_r.page <= byte_w[eeprom_pkg::ADDR_W-1 -: eeprom_pkg::PAGE_W];
      end
      if (byte_done && state_r == eeprom_pkg::ST_WDATA) begin
        xfer_r.act <= eeprom_pkg::ACT_WR;
        wmask_r[ptr_r[eeprom_pkg::OFS_W-1:0]] <= 1'b1;
      end
    end
  end

  always_ff @(posedge sck) begin
    if (hold_n && byte_done && state_r == eeprom_pkg::ST_WDATA) begin
      pbuf_r[ptr_r[eeprom_pkg::OFS_W-1:0]] <= byte_w;
    end
  end

  // ************************************************************
  // link side: serial output on the falling edge
  // ************************************************************
  always_ff @(negedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      so_o <= 1'b0;
      so_oe <= 1'b0;
    end else if (hold_n) begin
      so_o <= tx_r[eeprom_pkg::DATA_W-1];
      so_oe <= (state_r == eeprom_pkg::ST_RDATA) || (state_r == eeprom_pkg::ST_SRD);
    end else begin
      so_oe <= 1'b0;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  chk_busy_length: assert property (@(posedge sys_clk) disable iff (!rst_sync_r)
    $rose(busy_r) |-> busy_r [*8]) else $error("busy dropped early");
  chk_write_start: assert property (@(posedge sys_clk) disable iff (!rst_sync_r)
    (wr_go || swr_go) |=> busy_r && cnt_r == eeprom_pkg::CNT_W'(WRITE_CYCLES - 1))
    else $error("write cycle not started");
  chk_latch_done: assert property (@(posedge sys_clk) disable iff (!rst_sync_r)
    $fell(busy_r) |-> !permit_r) else $error("latch kept after write cycle");
  chk_protect_pin: assert property (@(posedge sys_clk) disable iff (!rst_sync_r)
    clk_en && !wp_s_r |=> !permit_r) else $error("latch set while protected");
  chk_guard_only: assert property (@(posedge sys_clk) disable iff (!rst_sync_r)
    !swr_go |=> $stable(bp_r)) else $error("guard bits changed without status write");
  chk_write_permit: assert property (@(posedge sys_clk) disable iff (!rst_sync_r)
    $rose(busy_r) |-> $past(permit_r) && $past(wp_s_r)) else $error("write started without permit");
  // a new frame restarts from a cleared state, so its first edge is exempt
  chk_bit_count: assert property (@(posedge sck) disable iff (!frame_rst_n)
    hold_n |=> frame_first || bit_cnt_r == $past(bit_cnt_r) + 3'h1) else $error("bit counter slipped");
  chk_hold_freeze: assert property (@(posedge sck) disable iff (!frame_rst_n)
    !hold_n |=> $stable(bit_cnt_r) && $stable(shift_r) && $stable(state_r)) else $error("moved during hold");
  chk_read_refused: assert property (@(posedge sck) disable iff (!frame_rst_n)
    byte_done && state_r == eeprom_pkg::ST_OPC && link_busy && byte_w[2:0] == eeprom_pkg::OPL_READ
    |=> state_r == eeprom_pkg::ST_IDLE) else $error("array read served while busy");
  chk_read_wrap: assert property (@(posedge sck) disable iff (!frame_rst_n)
    byte_done && state_r == eeprom_pkg::ST_RDATA |=> frame_first || ptr_r == $past(ptr_r) + eeprom_pkg::ADDR_STEP)
    else $error("read pointer not advanced");
  chk_page_wrap: assert property (@(posedge sck) disable iff (!frame_rst_n)
    byte_done && state_r == eeprom_pkg::ST_WDATA
    |=> frame_first
    || ptr_r[eeprom_pkg::ADDR_W-1 -: eeprom_pkg::PAGE_W] == $past(ptr_r[eeprom_pkg::ADDR_W-1 -: eeprom_pkg::PAGE_W]))
    else $error("page write left its page");

  cov_array_read: cover property (@(posedge sck) disable iff (!frame_rst_n)
    byte_done && state_r == eeprom_pkg::ST_RDATA);
  cov_page_commit: cover property (@(posedge sys_clk) disable iff (!rst_sync_r) wr_go);
  cov_status_write: cover property (@(posedge sys_clk) disable iff (!rst_sync_r) swr_go);
  cov_hold_mid_byte: cover property (@(posedge sck) disable iff (!frame_rst_n)
    !hold_n && bit_cnt_r != '0);

endmodule : eeprom_spi_engine

// >>> spi_host_model.sv
/*
 * Host side of the serial link: a behavioural controller that frames and shifts bytes.
 * Assumes the bench calls one task at a time; sck rests low between frames.
 */
`timescale 1ns/100ps
module spi_host_model (
  output logic sck, // serial clock, 80 ns period inside frames
  output logic cs_n, // chip select, active low
  output logic si, // serial data to the device
  output logic hold_n, // pause, active low
  input wire logic so_o, // serial data from the device
  input wire logic so_oe // device drives so_o
);
  // ************************************************************
  // frame and bit tasks
  // ************************************************************
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
  end

  // n bits of tx msb first; so_o is sampled just before each rise
  task automatic shift(input logic [7:0] tx, input int n, input int hold_at, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      if (i == hold_at) begin
        hold_n = 1'b0;
        repeat (2) begin
          #40 sck = 1'b1;
          si = ~si;
          #40 sck = 1'b0;
        end
        hold_n = 1'b1;
      end
      si = tx[i];
      #40 rx[i] = so_o;
      sck = 1'b1;
      #40 sck = 1'b0;
    end
  endtask : shift

  task automatic sel();
    cs_n = 1'b0;
    #40;
  endtask : sel

  // the gap lets the system side see the select rise and commit before the next frame
  task automatic desel();
    #40 cs_n = 1'b1;
    si = ~si;
    #400;
  endtask : desel
endmodule : spi_host_model

// >>> test_spi_eeprom_command_engine.sv
/*
 * Self-checking bench of the serial memory engine, driven through the host model.
 * Assumes a short write cycle parameter so that busy polling stays brief.
 */
`timescale 1ns/100ps
module test_spi_eeprom_command_engine;
  logic sys_clk, rst_b, wp_n, sck, cs_n, si, hold_n, so_o, so_oe, oe_seen;
  logic [7:0] rx, st;
  logic [7:0] rd [4];
  int n_errors = 0;
  int check_count = 0;

  eeprom_spi_engine #(.WRITE_CYCLES(400)) i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(1'b1), .sck(sck),
    .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so_o(so_o), .so_oe(so_oe));
  spi_host_model i_host (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so_o(so_o), .so_oe(so_oe));

  // ************************************************************
  // helpers
  // ************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sck) if (so_oe === 1'b1) oe_seen = 1'b1;

  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  task automatic cmd(input logic [7:0] op);
    i_host.sel();
    i_host.shift(op, 8, -1, rx);
    i_host.desel();
  endtask : cmd
  // hold is asserted once on the way in and once on the way out
  task automatic rd_status(output logic [7:0] s);
    i_host.sel();
    i_host.shift(8'h05, 8, 3, rx);
    i_host.shift(8'h00, 8, 4, s);
    i_host.desel();
  endtask : rd_status
  task automatic wait_idle(input logic [7:0] exp);
    rd_status(st);
    for (int k = 0; k < 20 && st[0] !== 1'b0; k++) rd_status(st);
    cmp("idle status", exp, st);
  endtask : wait_idle
  task automatic wr(input logic [7:0] op, input logic [7:0] a, input logic [7:0] d, input int n, input int last);
    i_host.sel();
    i_host.shift(op, 8, -1, rx);
    i_host.shift(a, 8, -1, rx);
    for (int i = 0; i < n; i++) i_host.shift(d + 8'(i), (i == n - 1) ? last : 8, -1, rx);
    i_host.desel();
  endtask : wr
  task automatic read_mem(input logic [7:0] op, input logic [7:0] a, input int n);
    oe_seen = 1'b0;
    i_host.sel();
    i_host.shift(op, 8, -1, rx);
    i_host.shift(a, 8, -1, rx);
    for (int i = 0; i < n; i++) i_host.shift(8'h00, 8, -1, rd[i]);
    i_host.desel();
  endtask : read_mem

  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    rst_b = 1'b0;
    wp_n = 1'b1;
    oe_seen = 1'b0;
    repeat (4) @(posedge sys_clk);
    #2 rst_b = 1'b1;
    repeat (4) @(posedge sys_clk);
    #2 rd_status(st);
    cmp("status", 8'h04, st);
    cmd(8'h0E);
    rd_status(st);
    cmp("status", 8'h06, st);
    cmd(8'h0C);
    rd_status(st);
    cmp("status", 8'h04, st);
    $display("test latch done");
    cmd(8'h06);
    wr(8'h01, 8'h00, 8'h00, 0, 8);
    rd_status(st);
    cmp("busy status", 8'h03, st);
    read_mem(8'h03, 8'h00, 1);
    cmp("refused read", 8'h00, {7'h00, oe_seen});
    wait_idle(8'h00);
    $display("test status write done");
    cmd(8'h06);
    wr(8'h02, 8'hFF, 8'hA0, 2, 8);
    wait_idle(8'h00);
    cmd(8'h06);
    wr(8'h0A, 8'h0E, 8'hB0, 3, 8);
    wait_idle(8'h00);
    read_mem(8'h0B, 8'hFF, 2);
    cmp("read ff", 8'hA0, rd[0]);
    cmp("read wrap", 8'hB2, rd[1]);
    cmp("output enable", 8'h00, {7'h00, so_oe});
    read_mem(8'h03, 8'hF0, 1);
    cmp("page wrap", 8'hA1, rd[0]);
    read_mem(8'h03, 8'h0E, 2);
    cmp("page data", 8'hB0, rd[0]);
    cmp("page data", 8'hB1, rd[1]);
    $display("test page write done");
    cmd(8'h06);
    wr(8'h02, 8'h0E, 8'h55, 1, 5);
    rd_status(st);
    cmp("aborted status", 8'h02, st);
    read_mem(8'h03, 8'h0E, 1);
    cmp("aborted data", 8'hB0, rd[0]);
    $display("test abort done");
    @(posedge sys_clk);
    #2 wp_n = 1'b0;
    repeat (4) @(posedge sys_clk);
    rd_status(st);
    cmp("protect status", 8'h00, st);
    cmd(8'h06);
    wr(8'h02, 8'h0E, 8'h11, 1, 8);
    read_mem(8'h03, 8'h0E, 1);
    cmp("protected data", 8'hB0, rd[0]);
    $display("test protect done");
    end_sim();
  end

  initial begin
    #400000;
    n_errors++;
    end_sim();
  end
endmodule : test_spi_eeprom_command_engine
